// File: design/sdl_target.sv
// What this block does
// - host starts every bit with falling edge
// - msb first, sixteen debug ticks per bit
// - 512 idle ticks abort the current command
// - perceived bit start lags edge up to one
// - sample host bit ten ticks after start
// - target releases pin during host bits
// - host drives pin high and low when sending
// - host holds read start low four ticks
// - host releases read low before tick seven
// - one: high speedup pulse at tick seven
// - zero: low thirteen ticks, then high pulse
// - host samples read bit near tick ten
// - select bit picks bus or alternate clock
// - bit timing counted on debug clock ticks; host probe counted in core cycles
// - pin level at reset picks start mode
// - rate probe answered with timed pulse
// - background-only commands refused while running
// - link works without resetting the target
// - host probe: long low, speedup, release
// - probe reply: wait, delay, 128 low, pulse
// - command opens with eight-bit code
`timescale 1ns/10ps
`default_nettype none

module sdl_fifo #(
  parameter int W = 9,
  parameter int D = 8
) (
  // clock and reset
  input  wire logic         core_clk_i,
  input  wire logic         rst_b_i,
  // fill side
  input  wire logic         in_valid_i,
  input  wire logic [W-1:0] in_data_i,
  output logic              in_ready_o,
  // drain side
  output logic              out_valid_o,
  output logic [W-1:0]      out_data_o,
  input  wire logic         out_ready_i
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;

  // output stage is a register, so one word more than D can be held
  assign in_ready_o = (cnt_q != (AW+1)'(D));
  assign push       = in_valid_i & in_ready_o;
  assign pop        = (cnt_q != '0) & (~out_valid_o | out_ready_i);

  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem[wr_q] <= in_data_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      out_valid_o <= 1'b0;
      out_data_o  <= '0;
    end else if (pop) begin
      out_valid_o <= 1'b1;
      out_data_o  <= mem[rd_q];
    end else if (out_ready_i) begin
      out_valid_o <= 1'b0;
    end
  end
endmodule

module sdl_target (
  // clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_b_i,
  // debug wire
  sdl_if.target           link,
  // debug clock choice: 1 bus clock, 0 alternate source
  input  wire logic       debug_clock_source_select_i,
  // mode control from the cpu side
  input  wire logic       bg_set_i,
  input  wire logic       bg_clr_i,
  input  wire logic       cmd_end_i,
  output logic            bg_mode_o,
  // bytes to return to the host
  input  wire logic       tx_valid_i,
  input  wire logic [7:0] tx_byte_i,
  output logic            tx_ready_o,
  // received bytes
  output logic            rx_valid_o,
  output logic [7:0]      rx_data_o,
  output logic            rx_is_cmd_o,
  input  wire logic       rx_ready_i,
  // status
  output logic            timeout_o,
  output logic            cmd_refused_o,
  output logic            rx_overrun_o,
  output logic            sync_active_o
);
  sdl_pkg::sdl_tgt_state_type st_q;
  logic [1:0]            div_q;
  logic                  tick;
  logic                  pin_q;
  logic                  fall;
  sdl_pkg::sdl_tick_type cnt_q;
  sdl_pkg::sdl_tick_type to_q;
  sdl_pkg::sdl_tick_type low_q;
  logic                  to_hit;
  logic                  sync_hit;
  logic                  frame_clr;
  logic                  tx_bit_q;
  logic                  rx_stb_q;
  logic                  rx_bit_q;
  logic                  tx_stb_q;
  logic                  started_q;
  logic [7:0]            rx_sh_q;
  logic [2:0]            rx_n_q;
  logic                  first_q;
  logic                  drop_q;
  logic                  push_q;
  logic [8:0]            push_word_q;
  logic                  fifo_ready;
  logic [7:0]            tx_sh_q;
  logic [2:0]            tx_n_q;
  logic [8:0]            rx_word;

  assign tick = debug_clock_source_select_i | (div_q == sdl_pkg::ALT_DIV_MAX);

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_q <= 2'h0;
    end else begin
      div_q <= (div_q == sdl_pkg::ALT_DIV_MAX) ? 2'h0 : div_q + 2'h1;
    end
  end

  // pin is taken as synchronous, so one stage both samples and detects
  assign fall = pin_q & ~link.pin;

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_q <= 1'b1;
    end else begin
      pin_q <= link.pin;
    end
  end

  // idle timer saturates so the abort fires once; a late host reconnects
  assign to_hit = tick & (to_q == sdl_pkg::TIMEOUT_TICKS - 10'h001);

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      to_q <= 10'h000;
    end else if (fall) begin
      to_q <= 10'h000;
    end else if (tick && to_q != sdl_pkg::TIMEOUT_TICKS) begin
      to_q <= to_q + 10'h001;
    end
  end

  // our own probe reply drives low too, so only idle and rx states count
  assign sync_hit = tick & (low_q == sdl_pkg::SYNC_DET - 10'h001) &
                    ((st_q == sdl_pkg::ST_IDLE) | (st_q == sdl_pkg::ST_RX));

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      low_q <= 10'h000;
    end else if (link.pin) begin
      low_q <= 10'h000;
    end else if (tick && low_q != sdl_pkg::SYNC_DET) begin
      low_q <= low_q + 10'h001;
    end
  end

  // bit engine and pin drive
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q         <= sdl_pkg::ST_IDLE;
      cnt_q        <= 10'h000;
      link.tgt_oe  <= 1'b0;
      link.tgt_out <= 1'b1;
      tx_bit_q     <= 1'b0;
      rx_stb_q     <= 1'b0;
      rx_bit_q     <= 1'b0;
      tx_stb_q     <= 1'b0;
    end else begin
      rx_stb_q <= 1'b0;
      tx_stb_q <= 1'b0;
      if (tick) begin
        cnt_q <= cnt_q + 10'h001;
      end
      if (sync_hit) begin
        st_q        <= sdl_pkg::ST_SWAIT;
        link.tgt_oe <= 1'b0;
      end else if (to_hit && st_q != sdl_pkg::ST_IDLE && st_q != sdl_pkg::ST_SWAIT) begin
        st_q        <= sdl_pkg::ST_IDLE;
        link.tgt_oe <= 1'b0;
      end else begin
        unique case (st_q)
          sdl_pkg::ST_IDLE: begin
            if (fall) begin
              cnt_q    <= 10'h000;
              tx_bit_q <= tx_sh_q[7];
              if (!tx_ready_o) begin
                st_q         <= sdl_pkg::ST_TX;
                link.tgt_oe  <= ~tx_sh_q[7];
                link.tgt_out <= 1'b0;
              end else begin
                st_q <= sdl_pkg::ST_RX;
              end
            end
          end
          sdl_pkg::ST_RX: begin
            if (tick && cnt_q == sdl_pkg::RX_SAMPLE - 10'h001) begin
              rx_stb_q <= 1'b1;
              rx_bit_q <= link.pin;
              st_q     <= sdl_pkg::ST_IDLE;
            end
          end
          sdl_pkg::ST_TX: begin
            if (tick && tx_bit_q && cnt_q == sdl_pkg::TX_ONE_PULSE - 10'h001) begin
              link.tgt_oe  <= 1'b1;
              link.tgt_out <= 1'b1;
            end else if (tick && !tx_bit_q && cnt_q == sdl_pkg::TX_ZERO_LOW - 10'h001) begin
              link.tgt_out <= 1'b1;
            end else if (tick && ((tx_bit_q && cnt_q == sdl_pkg::TX_ONE_PULSE) ||
                                  (!tx_bit_q && cnt_q == sdl_pkg::TX_ZERO_LOW))) begin
              link.tgt_oe <= 1'b0;
              tx_stb_q    <= 1'b1;
              st_q        <= sdl_pkg::ST_IDLE;
            end
          end
          sdl_pkg::ST_SWAIT: begin
            if (link.pin) begin
              cnt_q <= 10'h000;
              st_q  <= sdl_pkg::ST_SDELAY;
            end
          end
          sdl_pkg::ST_SDELAY: begin
            if (tick && cnt_q == sdl_pkg::SYNC_DELAY - 10'h001) begin
              cnt_q        <= 10'h000;
              link.tgt_oe  <= 1'b1;
              link.tgt_out <= 1'b0;
              st_q         <= sdl_pkg::ST_SLOW;
            end
          end
          sdl_pkg::ST_SLOW: begin
            if (tick && cnt_q == sdl_pkg::SYNC_LOW - 10'h001) begin
              link.tgt_out <= 1'b1;
              st_q         <= sdl_pkg::ST_SPULSE;
            end
          end
          sdl_pkg::ST_SPULSE: begin
            if (tick) begin
              link.tgt_oe <= 1'b0;
              st_q        <= sdl_pkg::ST_IDLE;
            end
          end
          // eighth code is unused; recover to idle with the pin released
          default: begin
            link.tgt_oe <= 1'b0;
            st_q        <= sdl_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  // a timeout, a probe or the decoder's end mark opens a new command
  assign frame_clr = to_hit | sync_hit | cmd_end_i;

  // receive byte assembly; first byte of a frame is the command code
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_sh_q       <= 8'h00;
      rx_n_q        <= 3'h0;
      first_q       <= 1'b1;
      drop_q        <= 1'b0;
      push_q        <= 1'b0;
      push_word_q   <= 9'h000;
      cmd_refused_o <= 1'b0;
    end else begin
      push_q        <= 1'b0;
      cmd_refused_o <= 1'b0;
      if (frame_clr) begin
        rx_n_q  <= 3'h0;
        first_q <= 1'b1;
        drop_q  <= 1'b0;
      end else if (rx_stb_q) begin
        rx_sh_q <= {rx_sh_q[6:0], rx_bit_q};
        rx_n_q  <= rx_n_q + 3'h1;
        if (rx_n_q == sdl_pkg::BYTE_LAST) begin
          first_q     <= 1'b0;
          push_word_q <= {first_q, rx_sh_q[6:0], rx_bit_q};
          if (first_q && !rx_sh_q[sdl_pkg::CMD_CLASS_BIT - 1] && !bg_mode_o) begin
            cmd_refused_o <= 1'b1;
            drop_q        <= 1'b1;
          end else begin
            push_q <= ~drop_q;
          end
        end
      end
    end
  end

  // transmit shifter; bit direction follows whether a byte is pending
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_sh_q    <= 8'h00;
      tx_n_q     <= 3'h0;
      tx_ready_o <= 1'b1;
    end else if (frame_clr) begin
      tx_ready_o <= 1'b1;
      tx_n_q     <= 3'h0;
    end else if (tx_valid_i && tx_ready_o) begin
      tx_sh_q    <= tx_byte_i;
      tx_n_q     <= 3'h0;
      tx_ready_o <= 1'b0;
    end else if (tx_stb_q) begin
      tx_sh_q <= {tx_sh_q[6:0], 1'b0};
      tx_n_q  <= tx_n_q + 3'h1;
      if (tx_n_q == sdl_pkg::BYTE_LAST) begin
        tx_ready_o <= 1'b1;
      end
    end
  end

  // strap caught on the first edge after reset release
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      started_q <= 1'b0;
      bg_mode_o <= 1'b0;
    end else if (!started_q) begin
      started_q <= 1'b1;
      bg_mode_o <= ~link.pin;
    end else if (bg_set_i) begin
      bg_mode_o <= 1'b1;
    end else if (bg_clr_i) begin
      bg_mode_o <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      timeout_o     <= 1'b0;
      rx_overrun_o  <= 1'b0;
      sync_active_o <= 1'b0;
    end else begin
      timeout_o     <= to_hit;
      // host cannot be stalled, so a full queue loses the byte
      rx_overrun_o  <= push_q & ~fifo_ready;
      sync_active_o <= (st_q == sdl_pkg::ST_SWAIT) | (st_q == sdl_pkg::ST_SDELAY) |
                       (st_q == sdl_pkg::ST_SLOW) | (st_q == sdl_pkg::ST_SPULSE);
    end
  end

  sdl_fifo #(
    .W (sdl_pkg::RX_FIFO_W),
    .D (sdl_pkg::RX_FIFO_DEPTH)
  ) u_rx_fifo (
    .core_clk_i  (core_clk_i),
    .rst_b_i     (rst_b_i),
    .in_valid_i  (push_q),
    .in_data_i   (push_word_q),
    .in_ready_o  (fifo_ready),
    .out_valid_o (rx_valid_o),
    .out_data_o  (rx_word),
    .out_ready_i (rx_ready_i)
  );

  assign rx_is_cmd_o = rx_word[8];
  assign rx_data_o   = rx_word[7:0];
endmodule
`default_nettype wire

// File: common/sdl_pkg.sv
package sdl_pkg;

  // all bit timing is counted in debug clock ticks
  typedef logic [9:0]  sdl_tick_type;
  typedef logic [15:0] sdl_cyc_type;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_TX,
    ST_SWAIT,
    ST_SDELAY,
    ST_SLOW,
    ST_SPULSE
  } sdl_tgt_state_type;

  typedef enum logic [2:0] {
    HS_IDLE,
    HS_BIT,
    HS_SLOW,
    HS_SPULSE,
    HS_SWAIT,
    HS_SMEAS
  } sdl_host_state_type;

  // core clock 20 MHz; alternate debug clock is core clock divided by four
  localparam logic [1:0]   ALT_DIV_MAX   = 2'h3;

  localparam sdl_tick_type BIT_TICKS     = 10'h010;
  localparam sdl_tick_type TIMEOUT_TICKS = 10'h200;
  localparam sdl_tick_type RX_SAMPLE     = 10'h00a;
  localparam sdl_tick_type TX_ONE_PULSE  = 10'h007;
  localparam sdl_tick_type TX_ZERO_LOW   = 10'h00d;
  localparam sdl_tick_type SYNC_DET      = 10'h080;
  localparam sdl_tick_type SYNC_DELAY    = 10'h010;
  localparam sdl_tick_type SYNC_LOW      = 10'h080;

  localparam sdl_tick_type HOST_READ_LOW = 10'h004;
  localparam sdl_tick_type HOST_ONE_LOW  = 10'h004;
  localparam sdl_tick_type HOST_ZERO_LOW = 10'h00d;
  localparam sdl_tick_type HOST_SAMPLE   = 10'h00a;

  // sync request lasts 128 ticks of the slowest debug clock, in core cycles
  localparam sdl_cyc_type  SYNC_HOST_LOW = sdl_cyc_type'(SYNC_LOW) *
                                           (sdl_cyc_type'(ALT_DIV_MAX) + 16'h0001);
  localparam sdl_cyc_type  SYNC_WAIT_MAX = 16'h0400;

  localparam logic [2:0]   BYTE_LAST     = 3'h7;
  localparam int           CMD_CLASS_BIT = 7;
  localparam int           RX_FIFO_DEPTH = 8;
  localparam int           RX_FIFO_W     = 9;

endpackage

// File: common/sdl_if.sv
`timescale 1ns/10ps
`default_nettype none
interface sdl_if;
  logic host_out;
  logic host_oe;
  logic tgt_out;
  logic tgt_oe;
  logic pin;

  // pseudo-open-drain wire with on-chip pullup
  assign pin = tgt_oe ? tgt_out : (host_oe ? host_out : 1'b1);

  modport target (input pin, output tgt_out, output tgt_oe);
  modport host   (input pin, output host_out, output host_oe);
endinterface
`default_nettype wire

// File: design/sdl_host.sv
`timescale 1ns/10ps
`default_nettype none

module sdl_host (
  // clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_b_i,
  // debug wire
  sdl_if.host             link,
  // must match the target's debug clock choice
  input  wire logic       debug_clock_source_select_i,
  // byte requests
  input  wire logic       req_valid_i,
  input  wire logic       req_read_i,
  input  wire logic [7:0] req_byte_i,
  output logic            req_ready_o,
  output logic            resp_valid_o,
  output logic [7:0]      resp_byte_o,
  // rate probe
  input  wire logic       sync_req_i,
  output logic            sync_done_o,
  output logic [15:0]     sync_len_o
);
  sdl_pkg::sdl_host_state_type st_q;
  logic [1:0]            div_q;
  logic                  tick;
  sdl_pkg::sdl_tick_type cnt_q;
  sdl_pkg::sdl_cyc_type  cyc_q;
  logic                  rd_q;
  logic [7:0]            sh_q;
  logic [2:0]            n_q;
  logic                  cur_bit;

  assign tick    = debug_clock_source_select_i | (div_q == sdl_pkg::ALT_DIV_MAX);
  assign cur_bit = sh_q[7];

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_q <= 2'h0;
    end else begin
      div_q <= (div_q == sdl_pkg::ALT_DIV_MAX) ? 2'h0 : div_q + 2'h1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q          <= sdl_pkg::HS_IDLE;
      cnt_q         <= 10'h000;
      cyc_q         <= 16'h0000;
      rd_q          <= 1'b0;
      sh_q          <= 8'h00;
      n_q           <= 3'h0;
      link.host_oe  <= 1'b0;
      link.host_out <= 1'b1;
      req_ready_o   <= 1'b1;
      resp_valid_o  <= 1'b0;
      resp_byte_o   <= 8'h00;
      sync_done_o   <= 1'b0;
      sync_len_o    <= 16'h0000;
    end else begin
      resp_valid_o <= 1'b0;
      sync_done_o  <= 1'b0;
      if (tick) begin
        cnt_q <= cnt_q + 10'h001;
      end
      unique case (st_q)
        sdl_pkg::HS_IDLE: begin
          if (sync_req_i && req_ready_o) begin
            cyc_q         <= 16'h0000;
            link.host_oe  <= 1'b1;
            link.host_out <= 1'b0;
            req_ready_o   <= 1'b0;
            st_q          <= sdl_pkg::HS_SLOW;
          end else if (req_valid_i && req_ready_o) begin
            sh_q          <= req_byte_i;
            rd_q          <= req_read_i;
            n_q           <= 3'h0;
            cnt_q         <= 10'h000;
            link.host_oe  <= 1'b1;
            link.host_out <= 1'b0;
            req_ready_o   <= 1'b0;
            st_q          <= sdl_pkg::HS_BIT;
          end
        end
        sdl_pkg::HS_BIT: begin
          if (tick) begin
            if (!rd_q && cnt_q == (cur_bit ? sdl_pkg::HOST_ONE_LOW : sdl_pkg::HOST_ZERO_LOW)
                                  - 10'h001) begin
              link.host_out <= 1'b1;
            end
            if (rd_q && cnt_q == sdl_pkg::HOST_READ_LOW - 10'h001) begin
              link.host_oe <= 1'b0;
            end
            if (rd_q && cnt_q == sdl_pkg::HOST_SAMPLE - 10'h001) begin
              sh_q <= {sh_q[6:0], link.pin};
            end
            if (cnt_q == sdl_pkg::BIT_TICKS - 10'h001) begin
              cnt_q <= 10'h000;
              n_q   <= n_q + 3'h1;
              if (!rd_q) begin
                sh_q <= {sh_q[6:0], 1'b0};
              end
              if (n_q == sdl_pkg::BYTE_LAST) begin
                link.host_oe <= 1'b0;
                req_ready_o  <= 1'b1;
                resp_valid_o <= rd_q;
                resp_byte_o  <= sh_q;
                st_q         <= sdl_pkg::HS_IDLE;
              end else begin
                link.host_oe  <= 1'b1;
                link.host_out <= 1'b0;
              end
            end
          end
        end
        sdl_pkg::HS_SLOW: begin
          cyc_q <= cyc_q + 16'h0001;
          if (cyc_q == sdl_pkg::SYNC_HOST_LOW - 16'h0001) begin
            link.host_out <= 1'b1;
            st_q          <= sdl_pkg::HS_SPULSE;
          end
        end
        sdl_pkg::HS_SPULSE: begin
          link.host_oe <= 1'b0;
          cyc_q        <= 16'h0000;
          st_q         <= sdl_pkg::HS_SWAIT;
        end
        sdl_pkg::HS_SWAIT: begin
          // a silent target must not hang the host
          cyc_q <= cyc_q + 16'h0001;
          if (!link.pin) begin
            cyc_q <= 16'h0001;
            st_q  <= sdl_pkg::HS_SMEAS;
          end else if (cyc_q == sdl_pkg::SYNC_WAIT_MAX) begin
            sync_done_o <= 1'b1;
            sync_len_o  <= 16'h0000;
            req_ready_o <= 1'b1;
            st_q        <= sdl_pkg::HS_IDLE;
          end
        end
        sdl_pkg::HS_SMEAS: begin
          if (link.pin) begin
            sync_done_o <= 1'b1;
            sync_len_o  <= cyc_q;
            req_ready_o <= 1'b1;
            st_q        <= sdl_pkg::HS_IDLE;
          end else if (cyc_q != 16'hffff) begin
            cyc_q <= cyc_q + 16'h0001;
          end
        end
        default: begin
          st_q <= sdl_pkg::HS_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// File: test/sdl_checker.sv
`timescale 1ns/10ps
`default_nettype none
module sdl_checker (
  // clock, reset, tick choice
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic debug_clock_source_select_i,
  // wire signals
  input wire logic host_out,
  input wire logic host_oe,
  input wire logic tgt_out,
  input wire logic tgt_oe,
  input wire logic pin
);
  // figures are in ticks, equal to core cycles only on the bus clock
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i || !debug_clock_source_select_i);
  logic       pin_q;
  logic       fall;
  logic [9:0] since_q;
  logic [7:0] low_q;
  logic [4:0] high_q;
  assign fall = pin_q && !pin && !tgt_oe;
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_q   <= 1'b1;
      since_q <= 10'h3ff;
    end else begin
      pin_q   <= pin;
      since_q <= fall ? 10'h000 : since_q + {9'h000, since_q != 10'h3ff};
    end
  end
  // saturating run lengths of target low and of pin high
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      low_q  <= 8'h00;
      high_q <= 5'h00;
    end else begin
      low_q  <= (tgt_oe && !tgt_out) ? low_q + {7'h00, low_q != 8'hff} : 8'h00;
      high_q <= !pin ? 5'h00 : high_q + {4'h0, high_q != 5'h1f};
    end
  end
  sequence s_lift;
    tgt_oe && tgt_out && $past(tgt_oe && !tgt_out);
  endsequence
  sequence s_sync_low;
    $rose(tgt_oe) && !tgt_out && since_q > 10'h020;
  endsequence
  a_pulse_short: assert property (
    tgt_oe && tgt_out |=> !(tgt_oe && tgt_out)) else $error("speedup pulse too long");
  a_one_time: assert property (
    $rose(tgt_oe) && tgt_out |-> since_q inside {[10'h006:10'h009]})
    else $error("one pulse off time");
  a_zero_high: assert property (
    s_lift ##0 since_q < 10'h020 |-> since_q inside {[10'h00c:10'h00f]})
    else $error("zero release off time");
  a_zero_len: assert property (
    s_lift ##0 since_q < 10'h020 |-> low_q inside {[8'h0b:8'h0e]}) else $error("zero low length");
  a_sync_len: assert property (
    s_lift ##0 since_q >= 10'h020 |-> low_q == 8'h80) else $error("sync reply length");
  a_sync_delay: assert property (
    s_sync_low |-> high_q inside {[5'h0f:5'h13]}) else $error("sync reply delay");
  a_no_fight: assert property (
    !(tgt_oe && host_oe && tgt_out != host_out)) else $error("drive conflict");
  a_start_held: assert property (
    fall && host_oe |=> !pin [*2]) else $error("bit start too short");
  a_bit_spacing: assert property (
    fall |-> since_q >= 10'h00f) else $error("bits too close");
endmodule
`default_nettype wire

// File: test/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic        clk, rst_b, sel, bg_set, bg_clr, cmd_end, tx_valid, rx_ready;
  logic        req_valid, req_read, sync_req, bg_mode, tx_ready, rx_valid, rx_is_cmd;
  logic        timeout, refused, overrun, req_ready, sync_done, to_seen, rf_seen, ov_seen;
  logic        resp_valid, sync_act, sa_seen;
  logic [7:0]  tx_byte, req_byte, rx_data, resp_byte;
  logic [15:0] sync_len;
  int          fails, check_count, k;
  sdl_if link ();
  sdl_target i_sdl_target (.core_clk_i(clk), .rst_b_i(rst_b), .link(link),
    .debug_clock_source_select_i(sel), .bg_set_i(bg_set), .bg_clr_i(bg_clr),
    .cmd_end_i(cmd_end), .bg_mode_o(bg_mode), .tx_valid_i(tx_valid), .tx_byte_i(tx_byte),
    .tx_ready_o(tx_ready), .rx_valid_o(rx_valid), .rx_data_o(rx_data),
    .rx_is_cmd_o(rx_is_cmd), .rx_ready_i(rx_ready), .timeout_o(timeout),
    .cmd_refused_o(refused), .rx_overrun_o(overrun), .sync_active_o(sync_act));
  sdl_host i_sdl_host (.core_clk_i(clk), .rst_b_i(rst_b), .link(link),
    .debug_clock_source_select_i(sel), .req_valid_i(req_valid), .req_read_i(req_read),
    .req_byte_i(req_byte), .req_ready_o(req_ready), .resp_valid_o(resp_valid),
    .resp_byte_o(resp_byte), .sync_req_i(sync_req), .sync_done_o(sync_done),
    .sync_len_o(sync_len));
  sdl_checker i_sdl_checker (.core_clk_i(clk), .rst_b_i(rst_b),
    .debug_clock_source_select_i(sel), .host_out(link.host_out), .host_oe(link.host_oe),
    .tgt_out(link.tgt_out), .tgt_oe(link.tgt_oe), .pin(link.pin));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // timeout, refusal and overrun pulses last one cycle and sync_act ends early, so they are latched here
  always @(posedge clk) begin
    if (timeout) to_seen = 1'b1;
    if (refused) rf_seen = 1'b1;
    if (overrun) ov_seen = 1'b1;
    if (sync_act) sa_seen = 1'b1;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic stall(input logic ok);
    if (ok !== 1'b1) begin
      chk(16'h0000, 16'h0001);
      wrap_up();
    end
  endtask
  task automatic xfer(input logic rd, input logic [7:0] b);
    int i;
    @(negedge clk);
    req_valid = 1'b1;
    req_read = rd;
    req_byte = b;
    @(negedge clk);
    req_valid = 1'b0;
    repeat (2) @(negedge clk);
    for (i = 0; i < 4000 && req_ready !== 1'b1; i++) @(negedge clk);
    stall(req_ready);
  endtask
  task automatic pop(input logic [7:0] b, input logic cmd);
    int i;
    for (i = 0; i < 40 && rx_valid !== 1'b1; i++) @(negedge clk);
    stall(rx_valid);
    chk(16'(rx_data), 16'(b));
    chk(16'(rx_is_cmd), 16'(cmd));
    rx_ready = 1'b1;
    @(negedge clk);
    rx_ready = 1'b0;
    @(negedge clk);
  endtask
  task automatic load(input logic [7:0] b);
    @(negedge clk);
    tx_valid = 1'b1;
    tx_byte = b;
    @(negedge clk);
    tx_valid = 1'b0;
  endtask
  task automatic t_write;
    chk(16'(bg_mode), 16'h0000);
    xfer(1'b0, 8'he4);
    xfer(1'b0, 8'h5a);
    pop(8'he4, 1'b1);
    pop(8'h5a, 1'b0);
    $display("test write done");
  endtask
  task automatic t_read(input logic [7:0] b);
    load(b);
    chk(16'(tx_ready), 16'h0000);
    xfer(1'b1, 8'h00);
    chk(16'(resp_byte), 16'(b));
    chk(16'(resp_valid), 16'h0001);
    chk(16'(tx_ready), 16'h0001);
    $display("test read done");
  endtask
  task automatic t_refuse;
    @(negedge clk);
    cmd_end = 1'b1;
    @(negedge clk);
    cmd_end = 1'b0;
    bg_set = k[0];
    rf_seen = 1'b0;
    xfer(1'b0, 8'h08);
    repeat (4) @(negedge clk);
    chk(16'(rf_seen), 16'(!k[0]));
    chk(16'(rx_valid), 16'(k[0]));
    bg_set = 1'b0;
    if (k[0]) pop(8'h08, 1'b1);
    $display("test command class done");
  endtask
  task automatic t_fifo;
    @(negedge clk);
    cmd_end = 1'b1;
    @(negedge clk);
    cmd_end = 1'b0;
    ov_seen = 1'b0;
    // output register plus eight slots, so the tenth byte is lost
    for (int i = 0; i < 10; i++) xfer(1'b0, 8'ha0 + 8'(i));
    chk(16'(ov_seen), 16'h0001);
    for (int i = 0; i < 9; i++) pop(8'ha0 + 8'(i), i == 0);
    chk(16'(rx_valid), 16'h0000);
    $display("test fifo done");
  endtask
  task automatic t_timeout;
    int i;
    to_seen = 1'b0;
    load(8'h77);
    for (i = 0; i < 700 && to_seen !== 1'b1; i++) @(negedge clk);
    stall(to_seen);
    chk(16'(tx_ready), 16'h0001);
    xfer(1'b0, 8'hc4);
    pop(8'hc4, 1'b1);
    $display("test timeout done");
  endtask
  task automatic t_sync(input logic s, input logic [15:0] exp);
    int i;
    sel = s;
    sa_seen = 1'b0;
    sync_req = 1'b1;
    @(negedge clk);
    sync_req = 1'b0;
    for (i = 0; i < 3000 && sync_done !== 1'b1; i++) @(negedge clk);
    stall(sync_done);
    chk(sync_len, exp);
    chk(16'(sa_seen), 16'h0001);
    xfer(1'b0, 8'he8);
    pop(8'he8, 1'b1);
    $display("test sync done");
  endtask
  initial begin
    {rst_b, sel, bg_set, bg_clr, cmd_end, tx_valid, rx_ready} = 7'h20;
    {req_valid, req_read, sync_req, tx_byte, req_byte} = 19'h00000;
    {fails, check_count, k} = '0;
    {to_seen, rf_seen, ov_seen, sa_seen} = 4'h0;
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    repeat (2) @(negedge clk);
    t_write();
    t_read(8'ha6);
    t_read(8'h59);
    t_refuse();
    k = 1;
    t_refuse();
    bg_clr = 1'b1;
    @(negedge clk);
    bg_clr = 1'b0;
    @(negedge clk);
    chk(16'(bg_mode), 16'h0000);
    t_fifo();
    t_timeout();
    t_sync(1'b1, 16'h0080);
    t_sync(1'b0, 16'h0200);
    wrap_up();
  end
  initial begin
    repeat (100000) @(posedge clk);
    stall(1'b0);
  end
endmodule
`default_nettype wire
